// ---- shared/spi_pin_pkg.sv ----
package spi_pin_pkg;
  // Master serial clock half period, as a time and as bus cycles
  localparam int CLK_MHZ = 100;
  localparam int SCK_HALF_NS = 40;
  localparam int SCK_HALF_CYCLES = (SCK_HALF_NS * CLK_MHZ + 999) / 1000;
  localparam int DATA_BITS = 8;
  localparam int SYNC_PINS = 4;
  // Synchronised pin vector positions
  localparam int PIN_SCK = 0;
  localparam int PIN_MOSI = 1;
  localparam int PIN_MISO = 2;
  localparam int PIN_SEL = 3;
  // Values after reset
  localparam logic RST_CTRL_BIT = 1'b0;
  localparam logic RST_FLAG = 1'b0;
  localparam logic RST_OE_N = 1'b1;
  localparam logic RST_PIN_HIGH = 1'b1;
  localparam logic RST_SCK_LEVEL = 1'b0;
  localparam logic [7:0] RST_DATA = 8'h00;

  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_DONE = 2'b11
  } xfer_state_t;
endpackage

// ---- core/pin_sync.sv ----
`timescale 1ns/10ps
module pin_sync
#(
  parameter int W = 4
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] level,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  logic [W-1:0] stageOneFf;
  logic [W-1:0] stageTwoFf;
  logic [W-1:0] stageThreeFf;
  logic [W-1:0] levelFf;
  logic [W-1:0] agree;
  logic [W-1:0] nxt_level;

  assign agree = ~(stageTwoFf ^ stageThreeFf);
  // A change counts only once stages two and three agree
  assign nxt_level = (agree & stageThreeFf) | (~agree & levelFf);
  assign level = levelFf;
  assign rise = nxt_level & ~levelFf;
  assign fall = ~nxt_level & levelFf;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      stageOneFf <= '1;
      stageTwoFf <= '1;
      stageThreeFf <= '1;
      levelFf <= '1;
    end
    else
    begin
      stageOneFf <= din;
      stageTwoFf <= stageOneFf;
      stageThreeFf <= stageTwoFf;
      levelFf <= nxt_level;
    end
  end
endmodule

// ---- core/spi_pin_mode_fault_power.sv ----
`timescale 1ns/10ps
// What this block does
// - Automatic select pin is low during a transfer, high when idle.
// - Automatic select only as master with select output and fault detect enabled.
// - No fault detection while automatic select output is enabled.
// - Single-pin mode uses the MOSI pin as master, MISO pin as slave.
// - Single-pin mode leaves MISO unused as master, MOSI unused as slave.
// - Shared pin direction follows bidir enable; it always feeds the shifter.
// - Serial clock pin is output as master, input as slave.
// - Select pin input or output as master, input as slave; single-pin irrelevant.
// - Master with fault detect enabled flags a fault when select goes low.
// - Master with fault detect disabled ignores select and keeps fault clear.
// - Slaves never raise a fault, bidirectional slaves included.
// - Fault makes the block a slave with all drivers off, transfer aborted.
// - Fault in single-pin master mode clears the bidir output enable.
// - Status read seeing fault, then control one write, clears the fault.
// - Module disabled stops the core while control bits stay writable.
// - Without halt-in-wait the block runs normally in wait.
// - With halt-in-wait a master pauses its transfer in wait and resumes.
// - A slave in wait keeps shifting and keeps sending the same data kind.
// - Slave completion in wait with halt-in-wait, or in retention stop, is deferred until exit.
// - Idle wait entry and exit produce no receive-full or data copy.
// - Retention stop freezes a master transfer; a slave stays in step.
// - Stop without retention disables the block and restores reset values.
// - Fault clears master select and aborts the current transfer.
// - Interrupt on fault or receive-full with enable set and module enabled.
module spi_pin_mode_fault_power
#(
  parameter int DATA_W = spi_pin_pkg::DATA_BITS,
  parameter int HALF_CYCLES = spi_pin_pkg::SCK_HALF_CYCLES
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ctrlOneWr,
  input wire logic moduleEnableIn,
  input wire logic masterSelectIn,
  input wire logic selectOutputEnableIn,
  input wire logic receiveInterruptEnableIn,
  input wire logic ctrlTwoWr,
  input wire logic faultDetectEnableIn,
  input wire logic singlePinSelectIn,
  input wire logic bidirOutputEnableIn,
  input wire logic haltInWaitIn,
  input wire logic statusRd,
  input wire logic dataRd,
  input wire logic txWr,
  input wire logic [DATA_W-1:0] txData,
  input wire logic waitMode,
  input wire logic stopRetain,
  input wire logic stopNoRetain,
  input wire logic sckIn,
  input wire logic mosiIn,
  input wire logic misoIn,
  input wire logic selectIn,
  output logic sckOut,
  output logic sckOeN,
  output logic mosiOut,
  output logic mosiOeN,
  output logic misoOut,
  output logic misoOeN,
  output logic selectOut,
  output logic selectOeN,
  output logic masterSelect,
  output logic bidirOutputEnable,
  output logic faultFlag,
  output logic receiveFullFlag,
  output logic [DATA_W-1:0] dataRegister,
  output logic irq
);
  localparam int EW = $clog2(2 * DATA_W);
  localparam int DW = $clog2(HALF_CYCLES + 1);
  localparam logic [EW-1:0] LAST_EDGE = EW'(2 * DATA_W - 1);
  localparam logic [DW-1:0] LAST_DIV = DW'(HALF_CYCLES - 1);

  logic moduleEnableFf;
  logic masterSelectFf;
  logic selectOutputEnableFf;
  logic receiveInterruptEnableFf;
  logic faultDetectEnableFf;
  logic singlePinSelectFf;
  logic bidirOeFf;
  logic haltInWaitFf;
  logic faultFf;
  logic statusSeenFf;
  logic receiveFullFf;
  logic pendingCopyFf;
  logic [DATA_W-1:0] dataRegisterFf;
  logic [DATA_W-1:0] shiftFf;
  logic [EW-1:0] edgeCntFf;
  logic [DW-1:0] divCntFf;
  logic sckLevelFf;
  spi_pin_pkg::xfer_state_t stateFf;
  logic sckOutFf;
  logic sckOeNFf;
  logic mosiOutFf;
  logic mosiOeNFf;
  logic misoOutFf;
  logic misoOeNFf;
  logic selectOutFf;
  logic selectOeNFf;
  logic irqFf;

  logic [spi_pin_pkg::SYNC_PINS-1:0] pinRaw;
  logic [spi_pin_pkg::SYNC_PINS-1:0] pinLevel;
  logic [spi_pin_pkg::SYNC_PINS-1:0] pinRise;
  logic [spi_pin_pkg::SYNC_PINS-1:0] pinFall;

  assign pinRaw = {selectIn, misoIn, mosiIn, sckIn};

  pin_sync #(.W(spi_pin_pkg::SYNC_PINS)) pinSyncInst
  (
    .clk(clk),
    .rst(rst),
    .din(pinRaw),
    .level(pinLevel),
    .rise(pinRise),
    .fall(pinFall)
  );

  wire selLevel = pinLevel[spi_pin_pkg::PIN_SEL];
  wire slaveSelected = !masterSelectFf && !selLevel;
  wire slaveSckRise = pinRise[spi_pin_pkg::PIN_SCK];
  wire slaveSckFall = pinFall[spi_pin_pkg::PIN_SCK];
  // Shared pin feeds the shifter in single-pin mode
  wire serialIn = masterSelectFf
    ? (singlePinSelectFf ? pinLevel[spi_pin_pkg::PIN_MOSI] : pinLevel[spi_pin_pkg::PIN_MISO])
    : (singlePinSelectFf ? pinLevel[spi_pin_pkg::PIN_MISO] : pinLevel[spi_pin_pkg::PIN_MOSI]);
  wire autoSelect = masterSelectFf && selectOutputEnableFf && faultDetectEnableFf;
  wire faultSet = moduleEnableFf && masterSelectFf && faultDetectEnableFf
    && !selectOutputEnableFf && !selLevel && !faultFf;
  wire faultClr = ctrlOneWr && statusSeenFf;
  wire masterHalt = stopRetain || (waitMode && haltInWaitFf);
  wire masterRun = moduleEnableFf && masterSelectFf && !faultFf && !masterHalt;
  wire slaveRun = moduleEnableFf && slaveSelected && !faultFf;
  wire slaveHold = !masterSelectFf && (stopRetain || (waitMode && haltInWaitFf));
  wire halfTick = masterRun && stateFf == spi_pin_pkg::ST_RUN && divCntFf == LAST_DIV;
  wire sampleEdge = masterSelectFf ? (halfTick && !sckLevelFf) : (slaveRun && slaveSckRise);
  wire shiftEdge = masterSelectFf ? (halfTick && sckLevelFf) : (slaveRun && slaveSckFall);
  // Master takes its bit on the clock fall, past the pin sync delay;
  // a slave shifts on the rise so its next bit settles before the next rise
  wire shiftLoad = masterSelectFf ? shiftEdge : sampleEdge;
  wire xferDone = stateFf == spi_pin_pkg::ST_DONE;
  wire doCopy = !slaveHold && (xferDone || pendingCopyFf) && !receiveFullFf;
  wire driveOk = moduleEnableFf && !faultFf;

  wire nxt_sckOeN = !(driveOk && masterSelectFf);
  wire nxt_mosiOeN = !(driveOk && masterSelectFf && (!singlePinSelectFf || bidirOeFf));
  wire nxt_misoOeN = !(driveOk && slaveSelected && (!singlePinSelectFf || bidirOeFf));
  wire nxt_selectOeN = !(driveOk && autoSelect);
  wire nxt_selectOut = stateFf == spi_pin_pkg::ST_IDLE;
  wire nxt_irq = moduleEnableFf && receiveInterruptEnableFf && (faultFf || receiveFullFf);

  // Control bits; stop without retention restores them
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      moduleEnableFf <= spi_pin_pkg::RST_CTRL_BIT;
      masterSelectFf <= spi_pin_pkg::RST_CTRL_BIT;
      selectOutputEnableFf <= spi_pin_pkg::RST_CTRL_BIT;
      receiveInterruptEnableFf <= spi_pin_pkg::RST_CTRL_BIT;
      faultDetectEnableFf <= spi_pin_pkg::RST_CTRL_BIT;
      singlePinSelectFf <= spi_pin_pkg::RST_CTRL_BIT;
      bidirOeFf <= spi_pin_pkg::RST_CTRL_BIT;
      haltInWaitFf <= spi_pin_pkg::RST_CTRL_BIT;
    end
    else if (stopNoRetain)
    begin
      moduleEnableFf <= spi_pin_pkg::RST_CTRL_BIT;
      masterSelectFf <= spi_pin_pkg::RST_CTRL_BIT;
      selectOutputEnableFf <= spi_pin_pkg::RST_CTRL_BIT;
      receiveInterruptEnableFf <= spi_pin_pkg::RST_CTRL_BIT;
      faultDetectEnableFf <= spi_pin_pkg::RST_CTRL_BIT;
      singlePinSelectFf <= spi_pin_pkg::RST_CTRL_BIT;
      bidirOeFf <= spi_pin_pkg::RST_CTRL_BIT;
      haltInWaitFf <= spi_pin_pkg::RST_CTRL_BIT;
    end
    else
    begin
      if (ctrlOneWr)
      begin
        moduleEnableFf <= moduleEnableIn;
        selectOutputEnableFf <= selectOutputEnableIn;
        receiveInterruptEnableFf <= receiveInterruptEnableIn;
      end
      if (faultSet)
        masterSelectFf <= 1'b0;
      else if (ctrlOneWr && (!faultFf || faultClr))
        masterSelectFf <= masterSelectIn;
      if (ctrlTwoWr)
      begin
        faultDetectEnableFf <= faultDetectEnableIn;
        singlePinSelectFf <= singlePinSelectIn;
        haltInWaitFf <= haltInWaitIn;
      end
      if (faultSet && singlePinSelectFf)
        bidirOeFf <= 1'b0;
      else if (ctrlTwoWr)
        bidirOeFf <= bidirOutputEnableIn;
    end
  end

  // Fault flag and its clear sequence; a new fault wins over the clear
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      faultFf <= spi_pin_pkg::RST_FLAG;
      statusSeenFf <= spi_pin_pkg::RST_FLAG;
    end
    else if (stopNoRetain)
    begin
      faultFf <= spi_pin_pkg::RST_FLAG;
      statusSeenFf <= spi_pin_pkg::RST_FLAG;
    end
    else
    begin
      if (faultSet)
        faultFf <= 1'b1;
      else if (faultClr || (masterSelectFf && !faultDetectEnableFf))
        faultFf <= 1'b0;
      if (ctrlOneWr)
        statusSeenFf <= 1'b0;
      else if (statusRd && faultFf)
        statusSeenFf <= 1'b1;
    end
  end

  // Transfer sequencing for both roles
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      stateFf <= spi_pin_pkg::ST_IDLE;
      edgeCntFf <= '0;
      divCntFf <= '0;
      sckLevelFf <= spi_pin_pkg::RST_SCK_LEVEL;
    end
    else if (stopNoRetain || faultSet || faultFf || !moduleEnableFf)
    begin
      stateFf <= spi_pin_pkg::ST_IDLE;
      edgeCntFf <= '0;
      divCntFf <= '0;
      sckLevelFf <= spi_pin_pkg::RST_SCK_LEVEL;
    end
    else
    begin
      case (stateFf)
        spi_pin_pkg::ST_IDLE:
        begin
          edgeCntFf <= '0;
          divCntFf <= '0;
          if ((masterRun && txWr) || slaveRun)
            stateFf <= spi_pin_pkg::ST_RUN;
        end
        spi_pin_pkg::ST_RUN:
        begin
          if (!masterSelectFf && !slaveSelected)
            stateFf <= spi_pin_pkg::ST_IDLE;
          if (masterRun)
            divCntFf <= halfTick ? '0 : divCntFf + 1'b1;
          if (halfTick)
            sckLevelFf <= !sckLevelFf;
          if (sampleEdge || shiftEdge)
          begin
            edgeCntFf <= edgeCntFf + 1'b1;
            if (edgeCntFf == LAST_EDGE)
              stateFf <= spi_pin_pkg::ST_DONE;
          end
        end
        spi_pin_pkg::ST_DONE:
        begin
          edgeCntFf <= '0;
          stateFf <= (!masterSelectFf && slaveSelected) ? spi_pin_pkg::ST_RUN : spi_pin_pkg::ST_IDLE;
        end
        default:
          stateFf <= spi_pin_pkg::ST_IDLE;
      endcase
    end
  end

  // Shifter keeps the received byte, so an idle slave resends it
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      shiftFf <= '0;
    end
    else
    begin
      if (txWr && stateFf != spi_pin_pkg::ST_RUN)
        shiftFf <= txData;
      else if (shiftLoad)
        shiftFf <= {shiftFf[DATA_W-2:0], serialIn};
    end
  end

  // Receive copy, deferred while a slave is held in low power
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      receiveFullFf <= spi_pin_pkg::RST_FLAG;
      pendingCopyFf <= spi_pin_pkg::RST_FLAG;
      dataRegisterFf <= spi_pin_pkg::RST_DATA;
    end
    else if (stopNoRetain)
    begin
      receiveFullFf <= spi_pin_pkg::RST_FLAG;
      pendingCopyFf <= spi_pin_pkg::RST_FLAG;
      dataRegisterFf <= spi_pin_pkg::RST_DATA;
    end
    else
    begin
      if (xferDone && slaveHold)
        pendingCopyFf <= 1'b1;
      else if (!slaveHold)
        pendingCopyFf <= 1'b0;
      if (doCopy)
      begin
        receiveFullFf <= 1'b1;
        dataRegisterFf <= shiftFf;
      end
      else if (dataRd)
        receiveFullFf <= 1'b0;
    end
  end

  // Registered pin drivers
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sckOutFf <= spi_pin_pkg::RST_SCK_LEVEL;
      sckOeNFf <= spi_pin_pkg::RST_OE_N;
      mosiOutFf <= spi_pin_pkg::RST_PIN_HIGH;
      mosiOeNFf <= spi_pin_pkg::RST_OE_N;
      misoOutFf <= spi_pin_pkg::RST_PIN_HIGH;
      misoOeNFf <= spi_pin_pkg::RST_OE_N;
      selectOutFf <= spi_pin_pkg::RST_PIN_HIGH;
      selectOeNFf <= spi_pin_pkg::RST_OE_N;
      irqFf <= spi_pin_pkg::RST_FLAG;
    end
    else
    begin
      sckOutFf <= sckLevelFf;
      sckOeNFf <= nxt_sckOeN;
      mosiOutFf <= shiftFf[DATA_W-1];
      mosiOeNFf <= nxt_mosiOeN;
      misoOutFf <= shiftFf[DATA_W-1];
      misoOeNFf <= nxt_misoOeN;
      selectOutFf <= nxt_selectOut;
      selectOeNFf <= nxt_selectOeN;
      irqFf <= nxt_irq;
    end
  end

  assign sckOut = sckOutFf;
  assign sckOeN = sckOeNFf;
  assign mosiOut = mosiOutFf;
  assign mosiOeN = mosiOeNFf;
  assign misoOut = misoOutFf;
  assign misoOeN = misoOeNFf;
  assign selectOut = selectOutFf;
  assign selectOeN = selectOeNFf;
  assign masterSelect = masterSelectFf;
  assign bidirOutputEnable = bidirOeFf;
  assign faultFlag = faultFf;
  assign receiveFullFlag = receiveFullFf;
  assign dataRegister = dataRegisterFf;
  assign irq = irqFf;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  auto_select_low_a: assert property (autoSelect && stateFf != spi_pin_pkg::ST_IDLE |=> !selectOutFf)
    else $error("select pin not low during transfer");
  fault_set_a: assert property (faultSet && !stopNoRetain |=> faultFf && !masterSelectFf)
    else $error("fault not flagged");
  fault_ignored_a: assert property (masterSelectFf && !faultDetectEnableFf |=> !faultFf)
    else $error("fault raised with detect disabled");
  slave_no_fault_a: assert property (!masterSelectFf && !faultFf |=> !faultFf)
    else $error("slave raised a fault");
  fault_pins_off_a: assert property (faultFf && $past(faultFf) |-> sckOeNFf && mosiOeNFf && misoOeNFf)
    else $error("driver on during fault");
  fault_abort_a: assert property (faultSet |=> stateFf == spi_pin_pkg::ST_IDLE ##1 stateFf == spi_pin_pkg::ST_IDLE)
    else $error("transfer not aborted on fault");
  fault_clear_a: assert property (faultClr && !faultSet |=> !faultFf)
    else $error("fault not cleared by sequence");
  defer_copy_a: assert property (slaveHold |=> !$rose(receiveFullFf))
    else $error("copy during slave low power");
  bidir_master_a: assert property (masterSelectFf && singlePinSelectFf && !bidirOeFf |=> mosiOeNFf && misoOeNFf)
    else $error("shared pin driven as input");
  slave_sck_in_a: assert property (!masterSelectFf |=> sckOeNFf)
    else $error("slave drives serial clock");
  stop_reset_a: assert property (stopNoRetain |=> !masterSelectFf && !receiveFullFf && !faultFf)
    else $error("state kept through stop");
endmodule

// ---- testbench/spi_far_end.sv ----
`timescale 1ns/10ps
module spi_far_end
(
  input wire logic clk,
  input wire logic lead,
  input wire logic go,
  input wire logic [7:0] txByte,
  input wire logic sckLine,
  input wire logic dIn,
  output logic sckDrv,
  output logic dOut,
  output logic [7:0] rxByte,
  output logic busy
);
  logic [7:0] sh;
  logic junk;
  int falls;
  initial
  begin
    sckDrv = 1'b0;
    busy = 1'b0;
    sh = 8'h00;
    junk = 1'b0;
    rxByte = 8'h00;
    falls = 0;
  end
  // Released line toggles so a stale bit never reads as valid
  always @(posedge clk)
    junk <= ~junk;
  assign dOut = busy ? sh[7] : junk;
  always @(posedge go)
  begin
    #1;
    sh = txByte;
    falls = 0;
    busy = 1'b1;
    if (lead)
    begin
      repeat (8)
      begin
        #40 sckDrv = 1'b1;
        #40 sckDrv = 1'b0;
      end
      #40 busy = 1'b0;
    end
  end
  // Sample on rise, shift on fall, MSB first
  always @(posedge sckLine)
    if (busy)
      rxByte = {rxByte[6:0], dIn};
  always @(negedge sckLine)
    if (busy)
    begin
      sh = sh << 1;
      falls++;
      if (!lead && falls == 8)
        busy = 1'b0;
    end
endmodule

// ---- testbench/test_spi_pin_mode_fault_power.sv ----
`timescale 1ns/10ps
module test_spi_pin_mode_fault_power;
  logic clk, rst, ctrlOneWr, moduleEnableIn, masterSelectIn, selectOutputEnableIn, receiveInterruptEnableIn;
  logic ctrlTwoWr, faultDetectEnableIn, singlePinSelectIn, bidirOutputEnableIn, haltInWaitIn;
  logic statusRd, dataRd, txWr, waitMode, stopRetain, stopNoRetain, selN, lead, go;
  logic [7:0] txData, farTx, farRx, dataRegister;
  logic sckOut, sckOeN, mosiOut, mosiOeN, misoOut, misoOeN, selectOut, selectOeN;
  logic masterSelect, bidirOutputEnable, faultFlag, receiveFullFlag, irq, sckDrv, farD, farBusy;
  logic sckLine, mosiLine, misoLine, selLine;
  int n_fail, n_checks, k;
  // Wire levels from the block's enables; the far end drives otherwise, selN the select line
  assign sckLine = !sckOeN ? sckOut : sckDrv;
  assign mosiLine = !mosiOeN ? mosiOut : farD;
  assign misoLine = !misoOeN ? misoOut : farD;
  assign selLine = !selectOeN ? selectOut : selN;
  spi_pin_mode_fault_power u_spi_pin_mode_fault_power
  (
    .clk(clk), .rst(rst), .ctrlOneWr(ctrlOneWr), .moduleEnableIn(moduleEnableIn),
    .masterSelectIn(masterSelectIn), .selectOutputEnableIn(selectOutputEnableIn),
    .receiveInterruptEnableIn(receiveInterruptEnableIn), .ctrlTwoWr(ctrlTwoWr),
    .faultDetectEnableIn(faultDetectEnableIn), .singlePinSelectIn(singlePinSelectIn),
    .bidirOutputEnableIn(bidirOutputEnableIn), .haltInWaitIn(haltInWaitIn), .statusRd(statusRd),
    .dataRd(dataRd), .txWr(txWr), .txData(txData), .waitMode(waitMode), .stopRetain(stopRetain),
    .stopNoRetain(stopNoRetain), .sckIn(sckLine), .mosiIn(mosiLine), .misoIn(misoLine),
    .selectIn(selLine), .sckOut(sckOut), .sckOeN(sckOeN), .mosiOut(mosiOut), .mosiOeN(mosiOeN),
    .misoOut(misoOut), .misoOeN(misoOeN), .selectOut(selectOut), .selectOeN(selectOeN),
    .masterSelect(masterSelect), .bidirOutputEnable(bidirOutputEnable), .faultFlag(faultFlag),
    .receiveFullFlag(receiveFullFlag), .dataRegister(dataRegister), .irq(irq)
  );
  spi_far_end u_spi_far_end
  (
    .clk(clk), .lead(lead), .go(go), .txByte(farTx), .sckLine(sckLine),
    .dIn(lead ? misoLine : mosiLine), .sckDrv(sckDrv), .dOut(farD), .rxByte(farRx), .busy(farBusy)
  );
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cfg1(input logic en, input logic ms, input logic so, input logic ie);
    @(posedge clk);
    ctrlOneWr <= 1'b1;
    moduleEnableIn <= en;
    masterSelectIn <= ms;
    selectOutputEnableIn <= so;
    receiveInterruptEnableIn <= ie;
    @(posedge clk);
    ctrlOneWr <= 1'b0;
  endtask
  task automatic cfg2(input logic fd, input logic sp, input logic bo, input logic hw);
    @(posedge clk);
    ctrlTwoWr <= 1'b1;
    faultDetectEnableIn <= fd;
    singlePinSelectIn <= sp;
    bidirOutputEnableIn <= bo;
    haltInWaitIn <= hw;
    @(posedge clk);
    ctrlTwoWr <= 1'b0;
  endtask
  task automatic t_reset();
    @(negedge clk);
    chk("enables", 8'h0F, {sckOeN, mosiOeN, misoOeN, selectOeN});
    chk("flags", 8'h00, {faultFlag, receiveFullFlag, masterSelect, irq, sckOut});
    $display("t_reset done");
  endtask
  task automatic t_master();
    cfg2(1'b1, 1'b0, 1'b0, 1'b0);
    cfg1(1'b1, 1'b1, 1'b1, 1'b1);
    @(posedge clk);
    lead <= 1'b0;
    farTx <= 8'hA5;
    go <= 1'b1;
    txWr <= 1'b1;
    txData <= 8'h3C;
    waitMode <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    txWr <= 1'b0;
    repeat (6) @(negedge clk);
    chk("auto select", 8'h00, {selectOut, selectOeN});
    chk("sck driven", 8'h00, sckOeN);
    k = 0;
    while (receiveFullFlag !== 1'b1 && k < 400)
    begin
      @(negedge clk);
      k++;
    end
    repeat (3) @(negedge clk);
    chk("no fault", 8'h00, faultFlag);
    chk("master rx", 8'hA5, dataRegister);
    chk("far rx", 8'h3C, farRx);
    chk("irq rx", 8'h01, irq);
    chk("select idle", 8'h01, selectOut);
    @(posedge clk);
    waitMode <= 1'b0;
    dataRd <= 1'b1;
    @(posedge clk);
    dataRd <= 1'b0;
    @(negedge clk);
    chk("rx cleared", 8'h00, receiveFullFlag);
    $display("t_master done");
  endtask
  task automatic t_fault();
    cfg2(1'b1, 1'b1, 1'b1, 1'b0);
    cfg1(1'b1, 1'b1, 1'b0, 1'b1);
    repeat (4) @(negedge clk);
    chk("shared pin", 8'h00, mosiOeN);
    chk("miso unused", 8'h01, misoOeN);
    @(posedge clk);
    selN <= 1'b0;
    repeat (12) @(negedge clk);
    chk("fault set", 8'h01, faultFlag);
    chk("master off", 8'h00, masterSelect);
    chk("bidir oe", 8'h00, bidirOutputEnable);
    chk("released", 8'h07, {sckOeN, mosiOeN, misoOeN});
    chk("irq fault", 8'h01, irq);
    @(posedge clk);
    selN <= 1'b1;
    cfg1(1'b1, 1'b1, 1'b0, 1'b1);
    repeat (2) @(negedge clk);
    chk("fault held", 8'h01, faultFlag);
    chk("sck off", 8'h01, sckOeN);
    @(posedge clk);
    statusRd <= 1'b1;
    @(posedge clk);
    statusRd <= 1'b0;
    cfg1(1'b1, 1'b1, 1'b0, 1'b1);
    repeat (3) @(negedge clk);
    chk("fault clear", 8'h00, faultFlag);
    chk("master back", 8'h01, masterSelect);
    $display("t_fault done");
  endtask
  task automatic t_nodetect();
    cfg2(1'b0, 1'b0, 1'b0, 1'b0);
    cfg1(1'b1, 1'b1, 1'b1, 1'b0);
    @(posedge clk);
    selN <= 1'b0;
    repeat (20) @(negedge clk);
    chk("no fault", 8'h00, faultFlag);
    chk("still master", 8'h01, masterSelect);
    chk("no auto select", 8'h01, selectOeN);
    @(posedge clk);
    selN <= 1'b1;
    $display("t_nodetect done");
  endtask
  task automatic t_slave();
    cfg2(1'b1, 1'b0, 1'b0, 1'b1);
    cfg1(1'b1, 1'b0, 1'b0, 1'b1);
    @(posedge clk);
    txWr <= 1'b1;
    txData <= 8'h5A;
    lead <= 1'b1;
    farTx <= 8'h96;
    @(posedge clk);
    txWr <= 1'b0;
    selN <= 1'b0;
    waitMode <= 1'b1;
    repeat (4) @(posedge clk);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    k = 0;
    while (farBusy !== 1'b0 && k < 200)
    begin
      @(negedge clk);
      k++;
    end
    repeat (8) @(negedge clk);
    chk("deferred", 8'h00, receiveFullFlag);
    chk("slave sent", 8'h5A, farRx);
    chk("slave fault", 8'h00, faultFlag);
    chk("pins in", 8'h03, {sckOeN, selectOeN});
    @(posedge clk);
    waitMode <= 1'b0;
    repeat (6) @(negedge clk);
    chk("rx after wait", 8'h01, receiveFullFlag);
    chk("slave rx", 8'h96, dataRegister);
    @(posedge clk);
    selN <= 1'b1;
    dataRd <= 1'b1;
    @(posedge clk);
    dataRd <= 1'b0;
    waitMode <= 1'b1;
    repeat (10) @(posedge clk);
    waitMode <= 1'b0;
    repeat (10) @(negedge clk);
    chk("idle wait", 8'h00, receiveFullFlag);
    $display("t_slave done");
  endtask
  task automatic t_off();
    cfg1(1'b0, 1'b1, 1'b0, 1'b0);
    @(posedge clk);
    lead <= 1'b0;
    txWr <= 1'b1;
    @(posedge clk);
    txWr <= 1'b0;
    repeat (200) @(negedge clk);
    chk("bits writable", 8'h01, masterSelect);
    chk("no transfer", 8'h00, {receiveFullFlag, sckOut});
    cfg1(1'b1, 1'b1, 1'b0, 1'b1);
    @(posedge clk);
    stopNoRetain <= 1'b1;
    repeat (3) @(posedge clk);
    stopNoRetain <= 1'b0;
    @(negedge clk);
    chk("stop reset", 8'h00, {masterSelect, irq});
    chk("stop data", 8'h00, dataRegister);
    $display("t_off done");
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    {ctrlOneWr, moduleEnableIn, masterSelectIn, selectOutputEnableIn, receiveInterruptEnableIn} = 5'h0;
    {ctrlTwoWr, faultDetectEnableIn, singlePinSelectIn, bidirOutputEnableIn, haltInWaitIn} = 5'h0;
    {statusRd, dataRd, txWr, waitMode, stopRetain, stopNoRetain, lead, go} = 8'h00;
    txData = 8'h00;
    farTx = 8'h00;
    selN = 1'b1;
    rst = 1'b1;
    n_fail = 0;
    n_checks = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_master();
    t_fault();
    t_nodetect();
    t_slave();
    t_off();
    results();
  end
  initial
  begin
    #100000;
    n_fail++;
    results();
  end
endmodule
